// ===== logic/dms_supervisor.sv
// Data mode call supervisor: escape, break, timeouts, flow control and rates.
// Assumes pump and terminal inputs are synchronous to mclk; event inputs are one-cycle pulses.
// Behaviour
// RULE1: Calls are only started while the service class selects data.
// RULE2: Three escape characters from the terminal in data mode enter command mode.
// RULE3: Escape detection is off while the escape setting exceeds 127.
// RULE4: Low-speed non-MNP10 calls hang up when carrier is absent beyond the delay.
// RULE5: With retrain enabled, bad line quality starts a retrain.
// RULE6: Retrain repeats until quality is good; hang up after 30 seconds.
// RULE7: Hang up after the programmed interval without data either way.
// RULE8: Terminal or line data restarts the inactivity count.
// RULE9: Inactivity setting is 0 to 255 seconds; zero disables it.
// RULE10: Line slower than terminal throttles terminal by XOFF/XON or CTS.
// RULE11: Terminal RTS holds line data only when RTS flow is selected.
// RULE12: Terminal-ready changes act as the terminal-ready setting selects.
// RULE13: In automode the rate cap is the terminal rate when it is lower.
// RULE14: V.23 originate sends 75, receives 1200; answer reverses; report 1200.
// RULE15: BREAK from terminal or line acts as the break setting selects.
// RULE16: Remote cleardown in non-EC V.32 to V.90 ends the call.
// RULE17: Fall forward setting moves speed up or down in V.32 to V.90.
// RULE18: Tone dial while line is in use stays on hook, reports line in use.
// RULE19: Answering blocks data 2 seconds, or 4 in fax adaptive answer.
// RULE20: A one-second tick drives all timeouts; counters clear on reset.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module dms_supervisor #(
  parameter int TICK_CYC = dms_pkg::CLK_HZ * dms_pkg::TICK_S
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        dial_tone_req,
  input  wire logic        answer_req,
  input  wire logic        answer_fax,
  input  wire logic        line_in_use,
  input  wire logic        connect_done,
  input  wire logic        online_resume,
  input  wire logic        host_hangup,
  input  wire logic        carrier_det,
  input  wire logic        remote_cleardown,
  input  wire logic        ec_mode,
  input  wire logic        mnp10_mode,
  input  wire logic        line_quality_ok,
  input  wire logic        quality_up,
  input  wire logic        quality_down,
  input  wire logic        term_rx_valid,
  input  wire logic [7:0]  term_rx_char,
  input  wire logic        line_rx_valid,
  input  wire logic        term_break,
  input  wire logic        line_break,
  input  wire logic        term_ready,
  input  wire logic        term_rts,
  input  wire logic        line_tx_full,
  input  wire logic [15:0] line_rate,
  input  wire logic [15:0] term_rate,
  output logic             off_hook,
  output logic             data_mode,
  output logic             data_block,
  output logic             retrain_req,
  output logic             rate_up,
  output logic             rate_down,
  output logic             hangup,
  output logic             esc_detect,
  output logic             break_fwd,
  output logic             send_xoff,
  output logic             send_xon,
  output logic             cts,
  output logic             rx_hold,
  output logic             result_valid,
  output logic      [3:0]  result_code,
  output logic      [15:0] rate_cap,
  output logic      [15:0] tx_rate,
  output logic      [15:0] rx_rate,
  output logic      [15:0] report_rate
);
  import dms_pkg::*;

  dms_state_e  state;
  dms_state_e  next_state;
  logic [C_W-1:0] reg_ctrl;
  logic [7:0]  reg_esc;
  logic [7:0]  reg_carr;
  logic [7:0]  reg_inact;
  logic [3:0]  reg_mod;
  logic [24:0] tick_cnt;
  logic        tick;
  logic [7:0]  bill_cnt;
  logic [7:0]  bill_lim;
  logic [7:0]  retrain_cnt;
  logic [7:0]  carr_cnt;
  logic [7:0]  inact_cnt;
  logic [1:0]  esc_cnt;
  logic        term_ready_q;
  logic        throttle_q;
  logic        class_ok;
  logic        in_call;
  logic        esc_on;
  logic        esc_hit;
  logic        brk_evt;
  logic        dtr_fall;
  logic        carr_drop;
  logic        clear_drop;
  logic        inact_drop;
  logic        retr_drop;
  logic        drop;
  logic        throttle;
  logic [1:0]  flow;
  logic [1:0]  brk_resp;
  logic [1:0]  dtr_resp;

  assign flow = reg_ctrl[C_FLOW+:2];
  assign brk_resp = reg_ctrl[C_BRK+:2];
  assign dtr_resp = reg_ctrl[C_DTR+:2];
  assign class_ok = reg_ctrl[C_CLASS+:2] == CLASS_DATA;  // [RULE1]
  assign in_call = (state == S_DATA) || (state == S_RETRAIN) || (state == S_ONCMD);
  assign esc_on = reg_esc <= ESC_MAX;  // [RULE3]
  assign esc_hit = (state == S_DATA) && term_rx_valid && esc_on && (term_rx_char == reg_esc)
                   && (esc_cnt == ESC_LAST);  // [RULE2]
  assign brk_evt = (state == S_DATA) && (term_break || line_break);  // [RULE15]
  assign dtr_fall = term_ready_q && !term_ready;
  assign carr_drop = in_call && !dms_high_mod(reg_mod) && !mnp10_mode && (carr_cnt > reg_carr);  // [RULE4]
  assign clear_drop = in_call && remote_cleardown && !ec_mode && dms_high_mod(reg_mod);  // [RULE16]
  assign inact_drop = in_call && (reg_inact != 8'h00) && (inact_cnt >= reg_inact);  // [RULE7] [RULE9]
  assign retr_drop = (state == S_RETRAIN) && (retrain_cnt >= RETRAIN_T);  // [RULE6]
  assign drop = carr_drop || clear_drop || inact_drop || retr_drop
                || (in_call && dtr_fall && dtr_resp == DTR_HANG)  // [RULE12]
                || (brk_evt && brk_resp == BRK_HANG)
                || ((state != S_IDLE) && host_hangup);
  assign throttle = in_call && (line_rate < term_rate) && line_tx_full;  // [RULE10]

  // Register writes
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_ctrl <= CTRL_RST;
      reg_esc <= ESC_RST;
      reg_carr <= CARR_RST;
      reg_inact <= INACT_RST;
      reg_mod <= MOD_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        A_CTRL: reg_ctrl <= reg_wdata[C_W-1:0];
        A_ESC: reg_esc <= reg_wdata[7:0];
        A_CARR: reg_carr <= reg_wdata[7:0];
        A_INACT: reg_inact <= reg_wdata[7:0];
        A_MOD: reg_mod <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  // Register reads, data valid the cycle after the strobe only
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        A_CTRL: reg_rdata <= {20'h00000, reg_ctrl};
        A_ESC: reg_rdata <= {24'h000000, reg_esc};
        A_CARR: reg_rdata <= {24'h000000, reg_carr};
        A_INACT: reg_rdata <= {24'h000000, reg_inact};
        A_MOD: reg_rdata <= {28'h0000000, reg_mod};
        A_STAT: reg_rdata <= {24'h000000, esc_cnt, throttle_q, off_hook, 1'b0, state};
        A_RATE: reg_rdata <= {rx_rate, tx_rate};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // One-second tick
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt <= 25'h0000000;
      tick <= 1'b0;
    end else if (tick_cnt >= 25'(TICK_CYC - 1)) begin  // [RULE20]
      tick_cnt <= 25'h0000000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 25'h0000001;
      tick <= 1'b0;
    end
  end

  // Answer billing delay
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bill_cnt <= 8'h00;
      bill_lim <= BILL_DATA_T;
    end else if (state == S_IDLE) begin
      bill_cnt <= 8'h00;
      bill_lim <= answer_fax ? BILL_FAX_T : BILL_DATA_T;  // [RULE19]
    end else if (state == S_BILL && tick) begin
      bill_cnt <= bill_cnt + 8'h01;
    end
  end

  // Retrain time limit
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      retrain_cnt <= 8'h00;
    end else if (state != S_RETRAIN) begin
      retrain_cnt <= 8'h00;
    end else if (tick && retrain_cnt != CNT_SAT) begin
      retrain_cnt <= retrain_cnt + 8'h01;  // [RULE6] [RULE20]
    end
  end

  // Carrier absence
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      carr_cnt <= 8'h00;
    end else if (!in_call || carrier_det) begin
      carr_cnt <= 8'h00;
    end else if (tick && carr_cnt != CNT_SAT) begin
      carr_cnt <= carr_cnt + 8'h01;  // [RULE4] [RULE20]
    end
  end

  // Inactivity
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      inact_cnt <= 8'h00;
    end else if (!in_call || term_rx_valid || line_rx_valid) begin
      inact_cnt <= 8'h00;  // [RULE8]
    end else if (tick && inact_cnt != CNT_SAT) begin
      inact_cnt <= inact_cnt + 8'h01;  // [RULE20]
    end
  end

  // Escape characters
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      esc_cnt <= 2'h0;
    end else if (state != S_DATA || !esc_on || esc_hit) begin
      esc_cnt <= 2'h0;  // [RULE3]
    end else if (term_rx_valid) begin
      esc_cnt <= (term_rx_char == reg_esc) ? esc_cnt + 2'h1 : 2'h0;  // [RULE2]
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      term_ready_q <= 1'b0;
      throttle_q <= 1'b0;
    end else begin
      term_ready_q <= term_ready;
      throttle_q <= throttle;
    end
  end

  // Call state
  always_comb begin
    next_state = state;
    if (drop) begin
      next_state = S_IDLE;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (class_ok && dial_tone_req && !line_in_use) begin  // [RULE1] [RULE18]
            next_state = S_WAIT;
          end else if (class_ok && answer_req && !dial_tone_req) begin
            next_state = S_BILL;
          end
        end
        S_BILL: begin
          if (bill_cnt >= bill_lim) begin  // [RULE19]
            next_state = S_WAIT;
          end
        end
        S_WAIT: begin
          if (connect_done) begin
            next_state = S_DATA;
          end
        end
        S_DATA: begin
          if (esc_hit || (brk_evt && brk_resp == BRK_CMD) || (dtr_fall && dtr_resp == DTR_CMD)) begin
            next_state = S_ONCMD;  // [RULE2] [RULE12] [RULE15]
          end else if (reg_ctrl[C_RETRAIN] && !line_quality_ok) begin
            next_state = S_RETRAIN;  // [RULE5]
          end
        end
        S_RETRAIN: begin
          if (line_quality_ok) begin
            next_state = S_DATA;  // [RULE6]
          end
        end
        S_ONCMD: begin
          if (online_resume) begin
            next_state = S_DATA;
          end
        end
        default: next_state = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Line and mode outputs, aligned with the state
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      off_hook <= 1'b0;
      data_mode <= 1'b0;
      data_block <= 1'b0;
      retrain_req <= 1'b0;
      hangup <= 1'b0;
      esc_detect <= 1'b0;
      break_fwd <= 1'b0;
    end else begin
      off_hook <= next_state != S_IDLE;
      data_mode <= next_state == S_DATA;
      data_block <= next_state == S_BILL;  // [RULE19]
      retrain_req <= next_state == S_RETRAIN;  // [RULE5]
      hangup <= drop;
      esc_detect <= esc_hit;
      break_fwd <= brk_evt && brk_resp == BRK_FWD;  // [RULE15]
    end
  end

  // Result codes
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      result_valid <= 1'b0;
      result_code <= 4'h0;
    end else if (state == S_IDLE && class_ok && dial_tone_req && line_in_use) begin
      result_valid <= 1'b1;
      result_code <= RES_LINE_IN_USE;  // [RULE18]
    end else if (drop) begin
      result_valid <= 1'b1;
      result_code <= RES_NO_CARRIER;
    end else begin
      result_valid <= 1'b0;
    end
  end

  // Speed adjust and terminal flow control
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rate_up <= 1'b0;
      rate_down <= 1'b0;
      send_xoff <= 1'b0;
      send_xon <= 1'b0;
      cts <= 1'b1;
      rx_hold <= 1'b0;
    end else begin
      rate_up <= (state == S_DATA) && reg_ctrl[C_FALLFWD] && dms_high_mod(reg_mod) && quality_up;  // [RULE17]
      rate_down <= (state == S_DATA) && reg_ctrl[C_FALLFWD] && dms_high_mod(reg_mod) && quality_down;
      send_xoff <= (flow == FLOW_XON) && throttle && !throttle_q;  // [RULE10]
      send_xon <= (flow == FLOW_XON) && !throttle && throttle_q;
      cts <= !((flow == FLOW_RTS) && throttle);
      rx_hold <= in_call && (flow == FLOW_RTS) && !term_rts;  // [RULE11]
    end
  end

  // Rates
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rate_cap <= R_56000;
      tx_rate <= R_1200;
      rx_rate <= R_1200;
      report_rate <= R_1200;
    end else begin
      if (reg_ctrl[C_AUTO] && term_rate < dms_max_rate(reg_mod)) begin
        rate_cap <= term_rate;  // [RULE13]
      end else begin
        rate_cap <= dms_max_rate(reg_mod);
      end
      if (reg_mod == 4'(M_V23)) begin
        tx_rate <= reg_ctrl[C_ORIG] ? R_75 : R_1200;  // [RULE14]
        rx_rate <= reg_ctrl[C_ORIG] ? R_1200 : R_75;
        report_rate <= R_1200;
      end else begin
        tx_rate <= line_rate;
        rx_rate <= line_rate;
        report_rate <= line_rate;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence seq_answer;
    state == S_IDLE && class_ok && answer_req && !dial_tone_req && !drop;
  endsequence
  sequence seq_blocked;
    data_block && off_hook && !data_mode;
  endsequence

  a_esc_cmd: assert property (esc_hit && !drop |=> state == S_ONCMD && esc_detect)  // [RULE2]
    else $error("escape did not enter command mode");
  a_esc_off: assert property (reg_esc > ESC_MAX |=> esc_cnt == 2'h0 && !esc_hit)  // [RULE3]
    else $error("escape counted while disabled");
  a_carr_drop: assert property (carr_drop |=> hangup && !off_hook && result_code == RES_NO_CARRIER)  // [RULE4]
    else $error("carrier loss did not hang up");
  a_retrain_go: assert property (state == S_DATA && reg_ctrl[C_RETRAIN] && !line_quality_ok && !drop && !esc_hit
                                 && !brk_evt && !dtr_fall |=> retrain_req)  // [RULE5]
    else $error("retrain not requested");
  a_retrain_max: assert property (state == S_RETRAIN |-> retrain_cnt <= RETRAIN_T)  // [RULE6]
    else $error("retrain exceeded limit");
  a_inact_drop: assert property (inact_drop |=> state == S_IDLE && !off_hook)  // [RULE7]
    else $error("inactivity did not hang up");
  a_inact_zero: assert property (reg_inact == 8'h00 |-> !inact_drop)  // [RULE9]
    else $error("inactivity fired while disabled");
  a_rts_hold: assert property (in_call && flow == FLOW_RTS && !term_rts |=> rx_hold)  // [RULE11]
    else $error("rts did not hold line data");
  a_v23_rate: assert property (reg_mod == 4'(M_V23) && reg_ctrl[C_ORIG] |=> tx_rate == R_75 && report_rate == R_1200)  // [RULE14]
    else $error("v23 rates wrong");
  a_clear_end: assert property (clear_drop |=> hangup && !off_hook ##1 !hangup)  // [RULE16]
    else $error("cleardown did not end call");
  a_line_busy: assert property (state == S_IDLE && class_ok && dial_tone_req && line_in_use
                                |=> !off_hook && result_valid && result_code == RES_LINE_IN_USE)  // [RULE18]
    else $error("line in use not refused");
  a_bill_block: assert property (disable iff (sys_rst || host_hangup) seq_answer |=> seq_blocked [*8])  // [RULE19]
    else $error("answer data block too short");
  a_class_gate: assert property (state == S_IDLE && !class_ok |=> !off_hook)  // [RULE1]
    else $error("call started outside data class");
endmodule : dms_supervisor
`default_nettype wire

// ===== logic/dms_pkg.sv
// Constants, types and helper functions for the data mode call supervisor.
// Assumes a single 20 MHz system clock; all timing is counted in one-second ticks.
package dms_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_S = 1;
  localparam int BILL_DATA_S = 2;
  localparam int BILL_FAX_S = 4;
  localparam int RETRAIN_S = 30;
  localparam logic [7:0] BILL_DATA_T = 8'(BILL_DATA_S / TICK_S);
  localparam logic [7:0] BILL_FAX_T = 8'(BILL_FAX_S / TICK_S);
  localparam logic [7:0] RETRAIN_T = 8'(RETRAIN_S / TICK_S);
  localparam logic [7:0] CNT_SAT = 8'hff;
  localparam logic [7:0] ESC_MAX = 8'h7f;
  localparam logic [1:0] ESC_LAST = 2'h2;

  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_ESC = 8'h04;
  localparam logic [7:0] A_CARR = 8'h08;
  localparam logic [7:0] A_INACT = 8'h0c;
  localparam logic [7:0] A_MOD = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_RATE = 8'h18;

  localparam int C_CLASS = 0;
  localparam int C_RETRAIN = 2;
  localparam int C_FALLFWD = 3;
  localparam int C_FLOW = 4;
  localparam int C_BRK = 6;
  localparam int C_DTR = 8;
  localparam int C_AUTO = 10;
  localparam int C_ORIG = 11;
  localparam int C_W = 12;
  localparam logic [11:0] CTRL_RST = 12'h404;
  localparam logic [7:0] ESC_RST = 8'h2b;
  localparam logic [7:0] CARR_RST = 8'h02;
  localparam logic [7:0] INACT_RST = 8'h00;

  localparam logic [1:0] CLASS_DATA = 2'h0;
  localparam logic [1:0] FLOW_XON = 2'h1;
  localparam logic [1:0] FLOW_RTS = 2'h2;
  localparam logic [1:0] BRK_FWD = 2'h1;
  localparam logic [1:0] BRK_CMD = 2'h2;
  localparam logic [1:0] BRK_HANG = 2'h3;
  localparam logic [1:0] DTR_CMD = 2'h1;
  localparam logic [1:0] DTR_HANG = 2'h2;
  localparam logic [3:0] RES_NO_CARRIER = 4'h3;
  localparam logic [3:0] RES_LINE_IN_USE = 4'h4;

  localparam logic [15:0] R_75 = 16'h004b;
  localparam logic [15:0] R_300 = 16'h012c;
  localparam logic [15:0] R_1200 = 16'h04b0;
  localparam logic [15:0] R_2400 = 16'h0960;
  localparam logic [15:0] R_9600 = 16'h2580;
  localparam logic [15:0] R_14400 = 16'h3840;
  localparam logic [15:0] R_33600 = 16'h8340;
  localparam logic [15:0] R_56000 = 16'hdac0;

  typedef enum logic [3:0] {M_V21, M_V22, M_V22B, M_V23, M_V32, M_V32B, M_V34, M_V90, M_B103, M_B212} dms_mod_e;
  typedef enum logic [2:0] {S_IDLE, S_BILL, S_WAIT, S_DATA, S_RETRAIN, S_ONCMD} dms_state_e;
  localparam logic [3:0] MOD_RST = 4'(M_V90);

  function automatic logic [15:0] dms_max_rate(input logic [3:0] m);
    unique case (m)
      4'(M_V21), 4'(M_B103): dms_max_rate = R_300;
      4'(M_V22), 4'(M_V23), 4'(M_B212): dms_max_rate = R_1200;
      4'(M_V22B): dms_max_rate = R_2400;
      4'(M_V32): dms_max_rate = R_9600;
      4'(M_V32B): dms_max_rate = R_14400;
      4'(M_V34): dms_max_rate = R_33600;
      default: dms_max_rate = R_56000;
    endcase
  endfunction : dms_max_rate

  function automatic logic dms_high_mod(input logic [3:0] m);
    dms_high_mod = (m >= 4'(M_V32)) && (m <= 4'(M_V90));
  endfunction : dms_high_mod
endpackage : dms_pkg

// ===== tb/dms_host_model.sv
// Host terminal model for the serial side of the call supervisor.
// Assumes one bench process calls its tasks; all changes follow mclk rising edges.
`timescale 1ns/1ps
`default_nettype none
module dms_host_model (
  input  wire logic       mclk,
  input  wire logic       cts,
  output logic            term_rx_valid,
  output logic      [7:0] term_rx_char,
  output logic            term_break,
  output logic            term_ready,
  output logic            term_rts
);
  initial begin
    term_rx_valid = 1'b0;
    term_rx_char  = 8'h00;
    term_break    = 1'b0;
    term_ready    = 1'b1;
    term_rts      = 1'b1;
  end
  // Send one character; idle data shows the inverse of the last one
  task automatic send_char(input logic [7:0] c);
    @(posedge mclk);
    while (cts !== 1'b1) @(posedge mclk);
    term_rx_valid <= 1'b1;
    term_rx_char  <= c;
    @(posedge mclk);
    term_rx_valid <= 1'b0;
    term_rx_char  <= ~c;
  endtask : send_char
  task automatic send_break;
    @(posedge mclk);
    term_break <= 1'b1;
    @(posedge mclk);
    term_break <= 1'b0;
  endtask : send_break
  task automatic set_lines(input logic rdy, input logic rts);
    @(posedge mclk);
    term_ready <= rdy;
    term_rts   <= rts;
  endtask : set_lines
endmodule : dms_host_model
`default_nettype wire

// ===== tb/tb_data_mode_call_supervisor.sv
// Self-checking bench for the call supervisor with random terminal traffic.
// Assumes the host model holds the terminal side; the bench plays the pump.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb_data_mode_call_supervisor;
  import dms_pkg::*;
  localparam int TK = 20;
  logic        mclk, sys_rst, reg_wr, reg_rd, liu, carr, lqok, full, fax;
  logic [7:0]  reg_addr, c;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [6:0]  ev;
  logic [15:0] line_rate, term_rate, rate_cap, report_rate;
  logic [3:0]  result_code;
  logic        off_hook, data_mode, data_block, retrain_req, hangup, esc_detect, cts, rx_hold, result_valid;
  logic        term_rx_valid, term_break, term_ready, term_rts;
  logic        brkf, xoff, xon, rup, rdn;
  logic [4:0]  aux;
  logic [7:0]  term_rx_char;
  int          err_count, n_checks, n;
  dms_supervisor #(.TICK_CYC(TK)) u_dut (
    .mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .dial_tone_req(ev[0]), .answer_req(ev[1]), .answer_fax(fax), .line_in_use(liu),
    .connect_done(ev[2]), .online_resume(ev[3]), .host_hangup(ev[4]), .carrier_det(carr),
    .remote_cleardown(ev[5]), .ec_mode(aux[0]), .mnp10_mode(aux[1]), .line_quality_ok(lqok),
    .quality_up(aux[2]), .quality_down(aux[3]), .term_rx_valid, .term_rx_char, .line_rx_valid(ev[6]),
    .term_break, .line_break(aux[4]), .term_ready, .term_rts, .line_tx_full(full), .line_rate, .term_rate,
    .off_hook, .data_mode, .data_block, .retrain_req, .rate_up(rup), .rate_down(rdn), .hangup, .esc_detect,
    .break_fwd(brkf), .send_xoff(xoff), .send_xon(xon), .cts, .rx_hold, .result_valid, .result_code, .rate_cap,
    .tx_rate(), .rx_rate(), .report_rate
  );
  dms_host_model u_host (.mclk, .cts, .term_rx_valid, .term_rx_char, .term_break, .term_ready, .term_rts);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Pulse pump events for one cycle; returns just after the sampling edge
  task automatic pulse(input logic [6:0] m);
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= 7'h00;
    #1;
  endtask : pulse
  task automatic call_up;
    pulse(7'h01);
    pulse(7'h04);
    `CHK(data_mode, 1'b1)
  endtask : call_up
  // Hang-up must come between lo and hi cycles, reported as no carrier
  task automatic await_hang(input int lo, input int hi);
    n = 0;
    #1;
    while (n < hi && hangup !== 1'b1) begin
      @(posedge mclk);
      #1 n++;
    end
    `CHK(hangup, 1'b1)
    `CHK(n >= lo, 1'b1)
    `CHK(result_code, RES_NO_CARRIER)
    `CHK(off_hook, 1'b0)
  endtask : await_hang
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    #(50 * 20000);
    err_count++;
    finish_test();
  end
  initial begin
    logic [7:0]  ad [6] = '{A_CTRL, A_ESC, A_CARR, A_INACT, A_MOD, 8'h1c};
    logic [31:0] ex [6] = '{32'h404, 32'h2b, 32'h2, 32'h0, 32'h7, 32'h0};
    err_count = 0;
    n_checks  = 0;
    {sys_rst, reg_wr, reg_rd, liu, carr, lqok, full, fax} = 8'h8c;
    {reg_addr, reg_wdata, ev, aux} = '0;
    void'($urandom(32'h8f45));
    line_rate = 16'(R_1200 + ($urandom % 16'h4000));
    term_rate = R_9600;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(ad[i], v);
      `CHK(v, ex[i])
    end
    `CHK(rate_cap, R_9600)
    wr(A_CTRL, 32'h405);
    pulse(7'h01);
    `CHK(off_hook, 1'b0)
    wr(A_CTRL, 32'h404);
    liu <= 1'b1;
    pulse(7'h01);
    `CHK({result_valid, result_code, off_hook}, {1'b1, RES_LINE_IN_USE, 1'b0})
    liu <= 1'b0;
    call_up();
    rd(A_STAT, v);
    `CHK(v[2:0], 3'h3)
    for (int i = 0; i < 6; i++) begin
      c = 8'($urandom);
      u_host.send_char(c == 8'h2b ? 8'h2a : c);
    end
    for (int k = 0; k < 4; k++) u_host.send_char(k == 2 ? 8'h41 : 8'h2b);
    #1 `CHK(esc_detect, 1'b0)
    u_host.send_char(8'h2b);
    u_host.send_char(8'h2b);
    #1 `CHK({esc_detect, data_mode}, 2'b10)
    pulse(7'h08);
    wr(A_CTRL, 32'h444);
    aux <= 5'h10;
    @(posedge mclk);
    #1 `CHK({brkf, data_mode}, 2'b11)
    aux <= 5'h00;
    wr(A_ESC, 32'h80);
    repeat (3) u_host.send_char(8'h80);
    #1 `CHK({esc_detect, data_mode}, 2'b01)
    pulse(7'h40);
    wr(A_INACT, 32'h3);
    for (int i = 0; i < 8; i++) begin
      repeat (TK) @(posedge mclk);
      pulse(7'h40);
      `CHK(off_hook, 1'b1)
    end
    await_hang(2 * TK, 3 * TK + 4);
    wr(A_INACT, 32'h0);
    wr(A_MOD, 32'h1);
    call_up();
    {aux, carr} <= 6'h04;
    repeat (4 * TK) @(posedge mclk);
    #1 `CHK(off_hook, 1'b1)
    {aux, carr} <= 6'h05;
    @(posedge mclk);
    {aux, carr} <= 6'h00;
    await_hang(2 * TK, 4 * TK + 4);
    carr <= 1'b1;
    wr(A_MOD, 32'h7);
    call_up();
    aux <= 5'h01;
    pulse(7'h20);
    `CHK(off_hook, 1'b1)
    aux <= 5'h00;
    pulse(7'h20);
    `CHK({hangup, result_code}, {1'b1, RES_NO_CARRIER})
    call_up();
    lqok <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 `CHK(retrain_req, 1'b1)
    await_hang(29 * TK, 31 * TK + 4);
    lqok <= 1'b1;
    wr(A_CTRL, 32'h6e4);
    line_rate <= R_2400;
    call_up();
    full <= 1'b1;
    u_host.set_lines(1'b1, 1'b0);
    repeat (3) @(posedge mclk);
    #1 `CHK({cts, rx_hold}, 2'b01)
    full <= 1'b0;
    u_host.set_lines(1'b1, 1'b1);
    wr(A_CTRL, 32'h6dc);
    full <= 1'b1;
    @(posedge mclk);
    #1 `CHK({xoff, xon}, 2'b10)
    {aux, full} <= 6'h08;
    @(posedge mclk);
    #1 `CHK({xoff, xon, rup}, 3'b011)
    aux <= 5'h08;
    @(posedge mclk);
    #1 `CHK({rup, rdn}, 2'b01)
    aux <= 5'h00;
    u_host.send_break();
    await_hang(0, 4);
    call_up();
    u_host.set_lines(1'b0, 1'b1);
    await_hang(0, 4);
    u_host.set_lines(1'b1, 1'b1);
    wr(A_MOD, 32'h3);
    for (int o = 0; o < 2; o++) begin
      wr(A_CTRL, 32'h404 | (o << 11));
      rd(A_RATE, v);
      `CHK(v, o ? {R_1200, R_75} : {R_75, R_1200})
      `CHK(report_rate, R_1200)
    end
    wr(A_MOD, 32'h7);
    fax <= 1'b1;
    pulse(7'h02);
    n = 0;
    while (n < 6 * TK && data_block === 1'b1) begin
      @(posedge mclk);
      #1 n++;
    end
    `CHK({off_hook, n >= 3 * TK, n <= 4 * TK + 3}, 3'b111)
    pulse(7'h10);
    finish_test();
  end
endmodule : tb_data_mode_call_supervisor
`default_nettype wire
